// ### rtl/fpi_pkg.sv
`default_nettype none
package fpi_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] MODE_IDX = 4'h1;
	localparam logic [ADDR_W-1:0] FLAG_IDX = 4'h2;
	localparam logic [ADDR_W-1:0] IEN_IDX = 4'h3;
	localparam logic [ADDR_W-1:0] STATE_IDX = 4'h4;
	localparam int MODE_STBY_POS = 5;
	localparam int FLG_MAIN_POS = 0;
	localparam int FLG_SECOND_POS = 1;
	localparam int FLG_OV_POS = 2;
	localparam int FLG_HOT_POS = 3;
	localparam int FLG_SHORT_POS = 4;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [4:0] IEN_RST = 5'h00;
	localparam int CLK_HZ = 25000000;
	localparam int BLANK_US = 4000;
	localparam int BLANK_CYC = (BLANK_US * (CLK_HZ / 1000000));
	typedef enum {FPI_STANDBY, FPI_SOFTSTART, FPI_RUN, FPI_OVGUARD, FPI_SHORT, FPI_HOT} fpi_state_e;
	typedef struct packed {
		logic short_low;
		logic ov_trip;
		logic ov_release;
		logic reg_clamp;
		logic hot_trip;
		logic office1;
		logic dark1;
		logic office2;
		logic dark2;
	} fpi_sense_s;
	typedef struct packed {
		logic pump_on;
		logic sinks_on;
		logic low_power;
		logic rout_boost;
		logic blank_active;
	} fpi_ctrl_s;
endpackage
`default_nettype wire

// ### rtl/fpi_fault_irq.sv
`timescale 1ns/100ps
`default_nettype none
module fpi_fault_irq #(
	parameter int BLANK_CYCLES = fpi_pkg::BLANK_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [fpi_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire fpi_pkg::fpi_sense_s sense_in,
	output fpi_pkg::fpi_ctrl_s ctrl_out,
	output logic irq_pin_n
);
	import fpi_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Analog comparator outputs are asynchronous: three stages, change when last two agree.
	fpi_sense_s s1_r, s2_r, s3_r, sense_r;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			sense_r <= '0;
		end
		else
		begin
			s1_r <= sense_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sense_r <= (s2_r & s3_r) | (sense_r & (s2_r | s3_r));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register access: one-cycle waitrequest for reads and writes alike.
	logic acc_done_r;
	logic req;
	logic wr_hit;
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~acc_done_r;
	assign wr_hit = avs_write & acc_done_r;
	always_ff @(posedge clk)
	begin
		if (srst)
			acc_done_r <= 1'b0;
		else
			acc_done_r <= req & ~acc_done_r;
	end

	logic stby_exit_r;
	logic [4:0] ien_r;
	logic restart_pulse;
	assign restart_pulse = wr_hit && avs_address == MODE_IDX && avs_writedata[MODE_STBY_POS];
	always_ff @(posedge clk)
	begin
		if (srst)
			ien_r <= IEN_RST;
		else if (wr_hit && avs_address == IEN_IDX)
			ien_r <= avs_writedata[4:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Fault sequencer.
	fpi_state_e state_r;
	logic [$clog2(BLANK_CYCLES+1)-1:0] blank_cnt_r;
	logic blank_done;
	assign blank_done = blank_cnt_r == '0;
	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= FPI_STANDBY;
		else if (sense_r.hot_trip && state_r != FPI_HOT)
			state_r <= FPI_HOT;
		else
		begin
			case (state_r)
				FPI_STANDBY, FPI_SHORT, FPI_HOT:
					if (restart_pulse && !sense_r.hot_trip)
						state_r <= FPI_SOFTSTART;
				FPI_SOFTSTART:
					if (blank_done)
						state_r <= FPI_RUN;
				FPI_RUN:
					if (sense_r.short_low)
						state_r <= FPI_SHORT;
					else if (sense_r.ov_trip)
						state_r <= FPI_OVGUARD;
				FPI_OVGUARD:
					if (sense_r.ov_release)
						state_r <= FPI_RUN;
				default:
					state_r <= FPI_STANDBY;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			blank_cnt_r <= '0;
		else if (restart_pulse)
			blank_cnt_r <= ($clog2(BLANK_CYCLES+1))'(BLANK_CYCLES);
		else if (!blank_done)
			blank_cnt_r <= blank_cnt_r - 1'b1;
	end

	// Clamp regulation is analog; logic only raises the output resistance while clamped in RUN.
	always_ff @(posedge clk)
	begin
		if (srst)
			ctrl_out <= '0;
		else
		begin
			ctrl_out.pump_on <= state_r == FPI_SOFTSTART || state_r == FPI_RUN;
			ctrl_out.sinks_on <= state_r == FPI_RUN || state_r == FPI_OVGUARD;
			ctrl_out.low_power <= state_r == FPI_SHORT || state_r == FPI_HOT || state_r == FPI_STANDBY;
			ctrl_out.rout_boost <= state_r == FPI_RUN && sense_r.reg_clamp;
			ctrl_out.blank_active <= !blank_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags; a set in the same cycle as a clear wins.
	fpi_sense_s prev_r;
	logic [4:0] flags_r;
	logic [4:0] set_ev;
	logic [4:0] clr;
	always_ff @(posedge clk)
	begin
		if (srst)
			prev_r <= '0;
		else
			prev_r <= sense_r;
	end
	always_comb
	begin
		set_ev = '0;
		set_ev[FLG_MAIN_POS] = (sense_r.office1 ^ prev_r.office1) | (sense_r.dark1 ^ prev_r.dark1);
		set_ev[FLG_SECOND_POS] = (sense_r.office2 ^ prev_r.office2) | (sense_r.dark2 ^ prev_r.dark2);
		set_ev[FLG_OV_POS] = state_r == FPI_RUN && !sense_r.short_low && sense_r.ov_trip && !sense_r.hot_trip;
		set_ev[FLG_HOT_POS] = sense_r.hot_trip;
		set_ev[FLG_SHORT_POS] = state_r == FPI_RUN && sense_r.short_low && !sense_r.hot_trip;
		clr = (wr_hit && avs_address == FLAG_IDX) ? avs_writedata[4:0] : 5'h00;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			flags_r <= FLAGS_RST;
		else
			flags_r <= (flags_r & ~clr) | set_ev;
	end
	assign irq_pin_n = ~|(flags_r & ien_r);

	////////////////////////////////////////////////////////////////////////
	logic [2:0] state_code;
	always_comb
	begin
		case (state_r)
			FPI_STANDBY: state_code = 3'h0;
			FPI_SOFTSTART: state_code = 3'h1;
			FPI_RUN: state_code = 3'h2;
			FPI_OVGUARD: state_code = 3'h3;
			FPI_SHORT: state_code = 3'h4;
			FPI_HOT: state_code = 3'h5;
			default: state_code = 3'h7;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !acc_done_r)
		begin
			case (avs_address)
				MODE_IDX: avs_readdata <= {26'h0, stby_exit_r, 5'h00};
				FLAG_IDX: avs_readdata <= {27'h0, flags_r};
				IEN_IDX: avs_readdata <= {27'h0, ien_r};
				STATE_IDX: avs_readdata <= {29'h0, state_code};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end
	// Standby-exit bit reads back high while the part is in SOFTSTART, RUN or OVGUARD; low in standby, short and overtemperature.
	always_ff @(posedge clk)
	begin
		if (srst)
			stby_exit_r <= 1'b0;
		else
			stby_exit_r <= !(state_r == FPI_STANDBY || state_r == FPI_SHORT || state_r == FPI_HOT);
	end
endmodule // fpi_fault_irq
`default_nettype wire

// ### verif/fpi_fault_irq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fpi_fault_irq_sva
import fpi_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [fpi_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire fpi_pkg::fpi_sense_s sense_in,
	input wire fpi_pkg::fpi_ctrl_s ctrl_out,
	input wire logic irq_pin_n
);
	wire acc = avs_write && !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////////////
	// Eight cycles of a held input cover the three-stage sync plus the edge filter.
	AST_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("Read not answered after one wait.");
	AST_IEN0: assert property (
		acc && avs_address == IEN_IDX && avs_writedata[4:0] == 5'h00 |=> irq_pin_n)
		else $error("Interrupt pin low with all enables off.");
	AST_W1C: assert property (
		($stable(sense_in) && !sense_in.hot_trip && !sense_in.short_low)[*8] ##0
		(acc && avs_address == FLAG_IDX && avs_writedata[4:0] == 5'h1F) |=> irq_pin_n)
		else $error("Interrupt pin low after clearing all flags.");
	AST_OV_PUMP: assert property (sense_in.ov_trip[*8] |-> !ctrl_out.pump_on)
		else $error("Pump still on during overvoltage.");
	AST_OV_RESUME: assert property (
		(ctrl_out.sinks_on && sense_in.ov_release && !sense_in.ov_trip)[*8] |-> ctrl_out.pump_on)
		else $error("Pump did not resume after overvoltage.");
	AST_HOT: assert property (
		sense_in.hot_trip[*8] |-> !ctrl_out.pump_on && !ctrl_out.sinks_on)
		else $error("Functions still on while overheated.");
	AST_CLAMP: assert property (
		sense_in.reg_clamp[*8] ##0 (ctrl_out.pump_on && ctrl_out.sinks_on) |-> ctrl_out.rout_boost)
		else $error("No resistance boost at clamp.");
	AST_BLANK: assert property (
		ctrl_out.blank_active && sense_in.short_low |=> !ctrl_out.low_power)
		else $error("Short sensed during blanking.");
	cover property (!irq_pin_n);
	cover property ($fell(ctrl_out.pump_on));
	cover property (ctrl_out.rout_boost);
endmodule // fpi_fault_irq_sva
`default_nettype wire

// ### verif/fpi_sense_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpi_sense_model
import fpi_pkg::*;
(
	input wire logic clk,
	input wire fpi_pkg::fpi_sense_s req,
	output fpi_pkg::fpi_sense_s sense
);
	// Comparators settle one cycle after the bench asks, never on the edge itself.
	always_ff @(posedge clk)
	begin
		sense <= req;
	end
endmodule // fpi_sense_model
`default_nettype wire

// ### verif/test_fault_protection_interrupts.sv
`timescale 1ns/100ps
`default_nettype none
module test_fault_protection_interrupts;
import fpi_pkg::*;
	logic clk = 0, srst = 1, rd = 0, wr = 0, irq_pin_n;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, q, rdat;
	logic wt;
	fpi_sense_s s = '0, sn;
	fpi_ctrl_s c;
	int fails = 0, n_checks = 0, cyc = 0;
	fpi_sense_model pm (.clk(clk), .req(s), .sense(sn));
	fpi_fault_irq #(.BLANK_CYCLES(20)) dut (.clk(clk), .srst(srst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wt), .sense_in(sn), .ctrl_out(c), .irq_pin_n(irq_pin_n));
	initial forever #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 3000) begin fails++; tally_and_finish(); end
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a; wr <= w; rd <= !w; wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		rd <= 0;
		wr <= 0;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin $display("ERROR %0t got %h exp %h", $time, g, e); fails++; end
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		cmp(q, e);
	endtask
	task w(input logic [3:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask
	task idle(input int k);
		repeat (k) @(posedge clk);
	endtask
	initial
	begin
		idle(3); srst <= 0;
		rdc(FLAG_IDX, 0); rdc(IEN_IDX, 0); rdc(4'hF, 0);
		w(IEN_IDX, 32'h1F); rdc(IEN_IDX, 32'h1F);
		s.office1 <= 1; idle(10); rdc(FLAG_IDX, 1);
		cmp(irq_pin_n, 0);
		w(FLAG_IDX, 0); rdc(FLAG_IDX, 1); w(FLAG_IDX, 1); rdc(FLAG_IDX, 0);
		cmp(irq_pin_n, 1);
		s.dark2 <= 1; w(IEN_IDX, 0); idle(10); rdc(FLAG_IDX, 2);
		cmp(irq_pin_n, 1);
		w(FLAG_IDX, 2); w(IEN_IDX, 32'h1F);
		s.short_low <= 1; w(MODE_IDX, 32'h20); rdc(STATE_IDX, 1);
		idle(30); rdc(STATE_IDX, 4); rdc(FLAG_IDX, 16);
		cmp(c.low_power, 1);
		s.short_low <= 0; w(FLAG_IDX, 16); w(MODE_IDX, 32'h20); rdc(STATE_IDX, 1);
		idle(30); s.reg_clamp <= 1; idle(10); cmp(c.rout_boost, 1);
		rdc(FLAG_IDX, 0); s.reg_clamp <= 0;
		repeat (2)
		begin
			s.ov_trip <= 1; s.ov_release <= 0; idle(10); rdc(STATE_IDX, 3);
			cmp(c.pump_on, 0); cmp(c.sinks_on, 1);
			rdc(FLAG_IDX, 4); w(FLAG_IDX, 4);
			s.ov_trip <= 0; s.ov_release <= 1; idle(10); cmp(c.pump_on, 1);
		end
		s.ov_release <= 0; s.hot_trip <= 1; idle(10); rdc(STATE_IDX, 5);
		cmp(c.sinks_on, 0); rdc(FLAG_IDX, 8);
		w(FLAG_IDX, 8); rdc(FLAG_IDX, 8);
		s.hot_trip <= 0; idle(10); w(FLAG_IDX, 32'h1F); idle(10); rdc(FLAG_IDX, 0);
		w(MODE_IDX, 32'h20); rdc(STATE_IDX, 1);
		tally_and_finish();
	end
endmodule // test_fault_protection_interrupts
bind fpi_fault_irq fpi_fault_irq_sva chk (.*);
`default_nettype wire
